/* include/rt_opt_pkg.sv */
package rt_opt_pkg;
	// ------------------------------------------------------------
	// Register map (word addresses on the host port)
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_MASTER_SETUP = 16'h0000;
	localparam logic [15:0] ADDR_T1_OPTIONS = 16'h0010;
	localparam logic [15:0] ADDR_T2_OPTIONS = 16'h0011;
	localparam logic [15:0] ADDR_T1_SELFTEST = 16'h001e;
	localparam logic [15:0] ADDR_T1_ALT_SELFTEST = 16'h001f;
	localparam logic [15:0] ADDR_T2_SELFTEST = 16'h0027;
	localparam logic [15:0] ADDR_T2_ALT_SELFTEST = 16'h0028;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_UNDEF_INVALID = 9;
	localparam int BIT_SEP_BCAST = 8;
	localparam int BIT_SIMPLIFIED = 7;
	localparam int BIT_TEMP_RX = 6;
	localparam int BIT_ALT_WORD = 5;
	localparam int BIT_T1_EXEC = 0;
	localparam int BIT_T2_EXEC = 1;
	localparam logic [15:0] OPTION_MASK = 16'h03e0;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// ------------------------------------------------------------
	// Mode code constants
	// ------------------------------------------------------------
	localparam logic [4:0] MC_RX_LAST_LOW = 5'h0f;
	localparam logic [4:0] MC_16 = 5'h10;
	localparam logic [4:0] MC_17 = 5'h11;
	localparam logic [4:0] MC_18 = 5'h12;
	localparam logic [4:0] MC_19 = 5'h13;
	localparam logic [4:0] MC_20 = 5'h14;
	localparam logic [4:0] MC_21 = 5'h15;
	localparam int HOLD_WORDS = 32;

	// Mode command decode request from the protocol engine
	typedef struct packed {
		logic valid;
		logic term_sel;
		logic tx_dir;
		logic [4:0] code;
		logic illegal;
		logic bcast;
	} mode_req_s;

	// Decode answer to the protocol engine
	typedef struct packed {
		logic valid;
		logic respond;
		logic update_status;
		logic msg_error;
		logic status_only;
		logic simplified;
		logic send_word;
		logic [15:0] word;
	} mode_ans_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COLLECT = 2'b01,
		ST_COMMIT = 2'b10
	} hold_state_e;
endpackage

/* src/rt_option_bits.sv */
// Contract
// - Transmit codes 17,20,21 are undefined
// - Receive codes 0 to 15 are undefined
// - Receive codes 16,18,19 are undefined
// - Invalid option resets low; undefined accepted
// - Legal accepted code answers, updates status
// - Illegal code: error, status word only
// - Option high: undefined codes fully ignored
// - Option high: broadcast data kept in separate buffers
// - Option low: broadcast shares normal buffer
// - Simplified option selects simplified mode handling
// - Temp option collects words in 32-word buffer
// - Copy held words only after clean message
// - Alt option low: answer self-test word
// - Alt option high: answer alternate test word
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rt_option_bits #(
	parameter int DEPTH = rt_opt_pkg::HOLD_WORDS
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire rt_opt_pkg::mode_req_s i_mode_req,
	output rt_opt_pkg::mode_ans_s o_mode_ans,
	input wire logic [15:0] i_selftest_status,
	input wire logic i_rx_word_valid,
	input wire logic i_rx_term_sel,
	input wire logic i_rx_bcast,
	input wire logic [15:0] i_rx_word,
	input wire logic i_msg_done,
	input wire logic i_msg_error,
	output logic o_store_valid,
	output logic o_store_term_sel,
	output logic o_store_bcast_area,
	output logic [4:0] o_store_index,
	output logic [15:0] o_store_word,
	output logic [1:0] o_separate_bcast,
	output logic [1:0] o_temp_rx_enable
);
	localparam int IW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [15:0] master_r, master_nxt;
	logic [15:0] opt_r [2];
	logic [15:0] opt_nxt [2];
	logic [15:0] stw_r [2];
	logic [15:0] stw_nxt [2];
	logic [15:0] alt_r [2];
	logic [15:0] alt_nxt [2];
	logic [15:0] rdata_r, rdata_nxt;

	// Host writes; each terminal copy is separate so a write touches one only
	always_comb begin
		master_nxt = master_r;
		opt_nxt = opt_r;
		stw_nxt = stw_r;
		alt_nxt = alt_r;
		// Device-controlled self-test bits track the protocol engine
		stw_nxt[0] = i_selftest_status;
		stw_nxt[1] = i_selftest_status;
		if (i_wr) begin
			case (i_addr)
				rt_opt_pkg::ADDR_MASTER_SETUP: master_nxt = i_wdata;
				rt_opt_pkg::ADDR_T1_OPTIONS: opt_nxt[0] = i_wdata & rt_opt_pkg::OPTION_MASK;
				rt_opt_pkg::ADDR_T2_OPTIONS: opt_nxt[1] = i_wdata & rt_opt_pkg::OPTION_MASK;
				rt_opt_pkg::ADDR_T1_ALT_SELFTEST: alt_nxt[0] = i_wdata;
				rt_opt_pkg::ADDR_T2_ALT_SELFTEST: alt_nxt[1] = i_wdata;
				default: begin
				end
			endcase
		end
		// Temp option is only meaningful with both terminals stopped; hold old value otherwise
		for (int t = 0; t < 2; t++) begin
			if (master_r[rt_opt_pkg::BIT_T1_EXEC] || master_r[rt_opt_pkg::BIT_T2_EXEC]) begin
				opt_nxt[t][rt_opt_pkg::BIT_TEMP_RX] = opt_r[t][rt_opt_pkg::BIT_TEMP_RX];
			end
		end
	end

	// Read mux, answer in the cycle after the strobe
	always_comb begin
		rdata_nxt = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				rt_opt_pkg::ADDR_MASTER_SETUP: rdata_nxt = master_r;
				rt_opt_pkg::ADDR_T1_OPTIONS: rdata_nxt = opt_r[0];
				rt_opt_pkg::ADDR_T2_OPTIONS: rdata_nxt = opt_r[1];
				rt_opt_pkg::ADDR_T1_SELFTEST: rdata_nxt = stw_r[0];
				rt_opt_pkg::ADDR_T1_ALT_SELFTEST: rdata_nxt = alt_r[0];
				rt_opt_pkg::ADDR_T2_SELFTEST: rdata_nxt = stw_r[1];
				rt_opt_pkg::ADDR_T2_ALT_SELFTEST: rdata_nxt = alt_r[1];
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	// Options clear on master reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			master_r <= rt_opt_pkg::RESET_WORD;
			opt_r[0] <= rt_opt_pkg::RESET_WORD;
			opt_r[1] <= rt_opt_pkg::RESET_WORD;
			stw_r[0] <= rt_opt_pkg::RESET_WORD;
			stw_r[1] <= rt_opt_pkg::RESET_WORD;
			alt_r[0] <= rt_opt_pkg::RESET_WORD;
			alt_r[1] <= rt_opt_pkg::RESET_WORD;
			rdata_r <= rt_opt_pkg::RESET_WORD;
		end else begin
			master_r <= master_nxt;
			opt_r <= opt_nxt;
			stw_r <= stw_nxt;
			alt_r <= alt_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign o_rdata = rdata_r;

	// ------------------------------------------------------------
	// Mode command decode
	// ------------------------------------------------------------
	rt_opt_pkg::mode_ans_s ans_r, ans_nxt;
	logic undef_code;
	logic [15:0] sel_opt;

	// Undefined code set: receive 0..16,18,19 and transmit 17,20,21
	always_comb begin
		sel_opt = opt_r[i_mode_req.term_sel];
		if (i_mode_req.tx_dir) begin
			undef_code = (i_mode_req.code == rt_opt_pkg::MC_17) ||
				(i_mode_req.code == rt_opt_pkg::MC_20) || (i_mode_req.code == rt_opt_pkg::MC_21);
		end else begin
			undef_code = (i_mode_req.code <= rt_opt_pkg::MC_RX_LAST_LOW) ||
				(i_mode_req.code == rt_opt_pkg::MC_16) || (i_mode_req.code == rt_opt_pkg::MC_18) ||
				(i_mode_req.code == rt_opt_pkg::MC_19);
		end
	end

	// Answer one cycle after each request
	always_comb begin
		ans_nxt = '0;
		if (i_mode_req.valid) begin
			ans_nxt.valid = 1'b1;
			if (undef_code && sel_opt[rt_opt_pkg::BIT_UNDEF_INVALID]) begin
				// No recognition, no reply, no status capture
				ans_nxt.respond = 1'b0;
			end else if (i_mode_req.illegal) begin
				ans_nxt.msg_error = 1'b1;
				ans_nxt.update_status = 1'b1;
				ans_nxt.respond = !i_mode_req.bcast;
				ans_nxt.status_only = !i_mode_req.bcast;
				ans_nxt.simplified = sel_opt[rt_opt_pkg::BIT_SIMPLIFIED];
			end else begin
				ans_nxt.respond = !i_mode_req.bcast;
				ans_nxt.update_status = 1'b1;
				ans_nxt.simplified = sel_opt[rt_opt_pkg::BIT_SIMPLIFIED];
				if (i_mode_req.tx_dir && i_mode_req.code == rt_opt_pkg::MC_19 && !i_mode_req.bcast) begin
					ans_nxt.send_word = 1'b1;
					ans_nxt.word = sel_opt[rt_opt_pkg::BIT_ALT_WORD] ? alt_r[i_mode_req.term_sel]
						: stw_r[i_mode_req.term_sel];
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ans_r <= '0;
		end else begin
			ans_r <= ans_nxt;
		end
	end
	assign o_mode_ans = ans_r;

	// ------------------------------------------------------------
	// Temporary receive holding buffer
	// ------------------------------------------------------------
	logic [15:0] hold_mem [DEPTH];
	rt_opt_pkg::hold_state_e st_r, st_nxt;
	logic [IW-1:0] cnt_r, cnt_nxt, rd_r, rd_nxt;
	logic term_r, term_nxt, bc_r, bc_nxt;
	logic sv_r, sv_nxt, st_term_r, st_term_nxt, st_bc_r, st_bc_nxt;
	logic [4:0] sidx_r, sidx_nxt;
	logic [15:0] sword_r, sword_nxt;
	logic [1:0] sep_r, tmp_r;
	logic direct;

	// Direct path when the owning terminal has the holding buffer off
	assign direct = !opt_r[i_rx_term_sel][rt_opt_pkg::BIT_TEMP_RX];

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rd_nxt = rd_r;
		term_nxt = term_r;
		bc_nxt = bc_r;
		sv_nxt = 1'b0;
		st_term_nxt = st_term_r;
		st_bc_nxt = st_bc_r;
		sidx_nxt = sidx_r;
		sword_nxt = sword_r;
		case (st_r)
			rt_opt_pkg::ST_IDLE: begin
				if (i_rx_word_valid && direct) begin
					sv_nxt = 1'b1;
					st_term_nxt = i_rx_term_sel;
					st_bc_nxt = i_rx_bcast && opt_r[i_rx_term_sel][rt_opt_pkg::BIT_SEP_BCAST];
					sidx_nxt = 5'(cnt_r);
					sword_nxt = i_rx_word;
					cnt_nxt = i_msg_done ? '0 : IW'(cnt_r + 1'b1);
				end else if (i_rx_word_valid) begin
					st_nxt = rt_opt_pkg::ST_COLLECT;
					term_nxt = i_rx_term_sel;
					bc_nxt = i_rx_bcast;
					cnt_nxt = IW'(1);
				end else if (i_msg_done) begin
					cnt_nxt = '0;
				end
			end
			rt_opt_pkg::ST_COLLECT: begin
				if (i_msg_done && i_msg_error) begin
					st_nxt = rt_opt_pkg::ST_IDLE;
					cnt_nxt = '0;
				end else if (i_msg_done) begin
					st_nxt = rt_opt_pkg::ST_COMMIT;
					rd_nxt = '0;
				end else if (i_rx_word_valid) begin
					cnt_nxt = IW'(cnt_r + 1'b1);
				end
			end
			rt_opt_pkg::ST_COMMIT: begin
				sv_nxt = 1'b1;
				st_term_nxt = term_r;
				st_bc_nxt = bc_r && opt_r[term_r][rt_opt_pkg::BIT_SEP_BCAST];
				sidx_nxt = 5'(rd_r);
				sword_nxt = hold_mem[rd_r];
				rd_nxt = IW'(rd_r + 1'b1);
				if (IW'(rd_r + 1'b1) == cnt_r || rd_r == IW'(DEPTH - 1)) begin
					st_nxt = rt_opt_pkg::ST_IDLE;
					cnt_nxt = '0;
				end
			end
			default: st_nxt = rt_opt_pkg::ST_IDLE;
		endcase
	end

	// Holding memory write, no reset needed on data storage
	always_ff @(posedge i_ref_clk) begin
		if (i_rx_word_valid && !direct) begin
			hold_mem[(st_r == rt_opt_pkg::ST_COLLECT) ? cnt_r : '0] <= i_rx_word;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= rt_opt_pkg::ST_IDLE;
			cnt_r <= '0;
			rd_r <= '0;
			term_r <= 1'b0;
			bc_r <= 1'b0;
			sv_r <= 1'b0;
			st_term_r <= 1'b0;
			st_bc_r <= 1'b0;
			sidx_r <= 5'h00;
			sword_r <= 16'h0000;
			sep_r <= 2'h0;
			tmp_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			term_r <= term_nxt;
			bc_r <= bc_nxt;
			sv_r <= sv_nxt;
			st_term_r <= st_term_nxt;
			st_bc_r <= st_bc_nxt;
			sidx_r <= sidx_nxt;
			sword_r <= sword_nxt;
			sep_r <= {opt_nxt[1][rt_opt_pkg::BIT_SEP_BCAST], opt_nxt[0][rt_opt_pkg::BIT_SEP_BCAST]};
			tmp_r <= {opt_nxt[1][rt_opt_pkg::BIT_TEMP_RX], opt_nxt[0][rt_opt_pkg::BIT_TEMP_RX]};
		end
	end

	assign o_store_valid = sv_r;
	assign o_store_term_sel = st_term_r;
	assign o_store_bcast_area = st_bc_r;
	assign o_store_index = sidx_r;
	assign o_store_word = sword_r;
	assign o_separate_bcast = sep_r;
	assign o_temp_rx_enable = tmp_r;
endmodule
`default_nettype wire

/* test/rt_option_bits_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rt_option_bits_chk #(
	parameter int DEPTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire rt_opt_pkg::mode_req_s i_mode_req,
	input wire rt_opt_pkg::mode_ans_s o_mode_ans,
	input wire logic i_rx_word_valid,
	input wire logic i_rx_term_sel,
	input wire logic i_rx_bcast,
	input wire logic [15:0] i_rx_word,
	input wire logic i_msg_done,
	input wire logic i_msg_error,
	input wire logic o_store_valid,
	input wire logic o_store_term_sel,
	input wire logic o_store_bcast_area,
	input wire logic [15:0] o_store_word,
	input wire logic [1:0] o_separate_bcast,
	input wire logic [1:0] o_temp_rx_enable
);
	// ----
	// Port relations
	// ----
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// Each request gets one answer, no answer without a request
	chk_ans_follows: assert property (i_mode_req.valid |=> o_mode_ans.valid)
		else $error("mode answer missing");
	chk_no_stray_ans: assert property (!i_mode_req.valid |=> !o_mode_ans.valid)
		else $error("mode answer without request");
	// Defined code 19 is never refused, so its outcome hangs on the table only
	chk_illegal_status: assert property (i_mode_req.valid && i_mode_req.illegal && !i_mode_req.bcast &&
		i_mode_req.tx_dir && i_mode_req.code == rt_opt_pkg::MC_19 |=> o_mode_ans.msg_error && !o_mode_ans.send_word)
		else $error("illegal code answered with data");
	chk_legal_reply: assert property (i_mode_req.valid && !i_mode_req.illegal && !i_mode_req.bcast &&
		i_mode_req.tx_dir && i_mode_req.code == rt_opt_pkg::MC_19 |=> o_mode_ans.respond && o_mode_ans.send_word)
		else $error("legal code not answered");
	// Direct storage passes each word on in the next cycle
	chk_store_follows: assert property (i_rx_word_valid && !o_temp_rx_enable[i_rx_term_sel] |=>
		o_store_valid && o_store_word == $past(i_rx_word) && o_store_term_sel == $past(i_rx_term_sel))
		else $error("word not stored directly");
	chk_bcast_area: assert property (i_rx_word_valid && !o_temp_rx_enable[i_rx_term_sel] |=>
		o_store_bcast_area == ($past(i_rx_bcast) && o_separate_bcast[$past(i_rx_term_sel)]))
		else $error("wrong storage area");
	chk_temp_holds: assert property (i_rx_word_valid && o_temp_rx_enable[i_rx_term_sel] |=> !o_store_valid)
		else $error("held word stored early");
	chk_error_no_copy: assert property (i_msg_done && i_msg_error |=> !o_store_valid [*3])
		else $error("copy after failed message");
endmodule
bind rt_option_bits rt_option_bits_chk #(.DEPTH(DEPTH)) rt_option_bits_chk_inst (.i_ref_clk, .i_rst, .i_mode_req,
	.o_mode_ans, .i_rx_word_valid, .i_rx_term_sel, .i_rx_bcast, .i_rx_word, .i_msg_done, .i_msg_error,
	.o_store_valid, .o_store_term_sel, .o_store_bcast_area, .o_store_word, .o_separate_bcast, .o_temp_rx_enable);
`default_nettype wire

/* test/bus_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
	input wire logic i_ref_clk,
	output rt_opt_pkg::mode_req_s o_mode_req,
	output logic o_rx_word_valid,
	output logic o_rx_term_sel,
	output logic o_rx_bcast,
	output logic [15:0] o_rx_word,
	output logic o_msg_done,
	output logic o_msg_error
);
	// Idle bus at start
	initial begin
		o_mode_req = '0;
		{o_rx_word_valid, o_rx_term_sel, o_rx_bcast, o_rx_word, o_msg_done, o_msg_error} = '0;
	end
	// Fields turn over once released so a stale value is never mistaken for a held one
	task automatic send_mode(input rt_opt_pkg::mode_req_s r);
		rt_opt_pkg::mode_req_s idle;
		idle = ~r;
		idle.valid = 1'b0;
		@(posedge i_ref_clk);
		o_mode_req <= r;
		@(posedge i_ref_clk);
		o_mode_req <= idle;
	endtask
	// Data words back to back, as a bus message delivers them
	task automatic send_words(input int n, input logic term, input logic bc);
		for (int i = 0; i < n; i++) begin
			@(posedge i_ref_clk);
			o_rx_word_valid <= 1'b1;
			o_rx_term_sel <= term;
			o_rx_bcast <= bc;
			o_rx_word <= 16'h5a00 + 16'(i);
		end
		@(posedge i_ref_clk);
		o_rx_word_valid <= 1'b0;
		o_rx_word <= ~o_rx_word;
	endtask
	task automatic end_msg(input logic err);
		@(posedge i_ref_clk);
		o_msg_done <= 1'b1;
		o_msg_error <= err;
		@(posedge i_ref_clk);
		o_msg_done <= 1'b0;
		o_msg_error <= ~err;
	endtask
endmodule
`default_nettype wire

/* test/rt_option_bits_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rt_option_bits_tb_top;
	typedef struct {logic [15:0] opt; logic term; logic dir; logic [4:0] code; logic ill; logic [5:0] exp;} row_s;
	// Expected answer bits: valid, respond, update, error, status only, simplified
	// The last two rows keep defined codes alive while the invalid option is set
	row_s rows[14] = '{'{16'h0000, 1'b0, 1'b1, 5'h11, 1'b0, 6'h38}, '{16'h0200, 1'b0, 1'b1, 5'h11, 1'b0, 6'h20},
		'{16'h0200, 1'b0, 1'b1, 5'h14, 1'b0, 6'h20}, '{16'h0200, 1'b0, 1'b1, 5'h15, 1'b0, 6'h20},
		'{16'h0200, 1'b0, 1'b0, 5'h00, 1'b0, 6'h20}, '{16'h0200, 1'b0, 1'b0, 5'h0f, 1'b0, 6'h20},
		'{16'h0200, 1'b0, 1'b0, 5'h10, 1'b0, 6'h20}, '{16'h0200, 1'b0, 1'b0, 5'h12, 1'b0, 6'h20},
		'{16'h0200, 1'b0, 1'b0, 5'h13, 1'b0, 6'h20}, '{16'h0200, 1'b1, 1'b0, 5'h00, 1'b0, 6'h38},
		'{16'h0000, 1'b0, 1'b1, 5'h13, 1'b1, 6'h3e}, '{16'h0080, 1'b0, 1'b1, 5'h13, 1'b0, 6'h39},
		'{16'h0200, 1'b0, 1'b1, 5'h13, 1'b0, 6'h38}, '{16'h0200, 1'b0, 1'b0, 5'h11, 1'b0, 6'h38}};
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, i_selftest_status = 16'h1234;
	wire rt_opt_pkg::mode_req_s i_mode_req;
	wire rt_opt_pkg::mode_ans_s o_mode_ans;
	wire logic i_rx_word_valid, i_rx_term_sel, i_rx_bcast, i_msg_done, i_msg_error;
	wire logic o_store_valid, o_store_term_sel, o_store_bcast_area;
	wire logic [15:0] o_rdata, i_rx_word, o_store_word;
	wire logic [4:0] o_store_index;
	wire logic [1:0] o_separate_bcast, o_temp_rx_enable;
	logic [22:0] got[$];
	int n_errors = 0, n_tests = 0;
	rt_option_bits #(.DEPTH(32)) rt_option_bits_inst (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_mode_req, .o_mode_ans, .i_selftest_status, .i_rx_word_valid, .i_rx_term_sel, .i_rx_bcast,
		.i_rx_word, .i_msg_done, .i_msg_error, .o_store_valid, .o_store_term_sel, .o_store_bcast_area,
		.o_store_index, .o_store_word, .o_separate_bcast, .o_temp_rx_enable);
	bus_ctrl_model bus_ctrl_model_inst (.i_ref_clk, .o_mode_req(i_mode_req), .o_rx_word_valid(i_rx_word_valid),
		.o_rx_term_sel(i_rx_term_sel), .o_rx_bcast(i_rx_bcast), .o_rx_word(i_rx_word), .o_msg_done(i_msg_done),
		.o_msg_error(i_msg_error));
	// ----
	// Clock, store monitor, shared tasks
	// ----
	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// Old values seen at the edge are the ones stood in the cycle just ended
	always @(posedge i_ref_clk) begin
		if (o_store_valid === 1'b1) begin
			got.push_back({o_store_term_sel, o_store_bcast_area, o_store_index, o_store_word});
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 check(o_rdata, exp);
	endtask
	task automatic mode(input logic t, input logic dr, input logic [4:0] c, input logic il,
		output rt_opt_pkg::mode_ans_s a);
		bus_ctrl_model_inst.send_mode({1'b1, t, dr, c, il, 1'b0});
		#1 a = o_mode_ans;
	endtask
	// Waits out a commit, then compares every store in order
	task automatic expect_msg(input int n, input logic term, input logic area);
		repeat (n + 4) @(posedge i_ref_clk);
		check(got.size(), n);
		for (int i = 0; i < n && i < got.size(); i++) begin
			check(got[i], {term, area, 5'(i), 16'h5a00 + 16'(i)});
		end
		got.delete();
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Run needs well under 2000 cycles
	initial begin
		#100us;
		n_errors++;
		give_verdict();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		rt_opt_pkg::mode_ans_s a;
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rdc(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0000);
		rdc(rt_opt_pkg::ADDR_T2_OPTIONS, 16'h0000);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rt_opt_pkg::ADDR_T1_OPTIONS, rows[i].opt);
			mode(rows[i].term, rows[i].dir, rows[i].code, rows[i].ill, a);
			check({a.valid, a.respond, a.update_status, a.msg_error, a.status_only, a.simplified}, rows[i].exp);
		end
		$display("mode table done");
		wr(rt_opt_pkg::ADDR_T1_OPTIONS, 16'hffff);
		rdc(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h03e0);
		wr(16'h0005, 16'hffff);
		rdc(16'h0005, 16'h0000);
		wr(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0000);
		wr(rt_opt_pkg::ADDR_T1_ALT_SELFTEST, 16'h5a5a);
		wr(rt_opt_pkg::ADDR_T2_ALT_SELFTEST, 16'h0c0c);
		wr(rt_opt_pkg::ADDR_T1_SELFTEST, 16'hffff);
		rdc(rt_opt_pkg::ADDR_T1_SELFTEST, 16'h1234);
		rdc(rt_opt_pkg::ADDR_T1_ALT_SELFTEST, 16'h5a5a);
		mode(1'b0, 1'b1, rt_opt_pkg::MC_19, 1'b0, a);
		check({a.send_word, a.word}, {1'b1, 16'h1234});
		wr(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0020);
		mode(1'b0, 1'b1, rt_opt_pkg::MC_19, 1'b0, a);
		check({a.send_word, a.word}, {1'b1, 16'h5a5a});
		wr(rt_opt_pkg::ADDR_T2_OPTIONS, 16'h0020);
		mode(1'b1, 1'b1, rt_opt_pkg::MC_19, 1'b0, a);
		check({a.send_word, a.word}, {1'b1, 16'h0c0c});
		// Illegal broadcast: error flagged, but nothing goes back on the bus
		bus_ctrl_model_inst.send_mode({1'b1, 1'b0, 1'b1, rt_opt_pkg::MC_19, 1'b1, 1'b1});
		#1 check({o_mode_ans.respond, o_mode_ans.msg_error, o_mode_ans.send_word}, 3'b010);
		$display("register test done");
		wr(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0100);
		wr(rt_opt_pkg::ADDR_T2_OPTIONS, 16'h0000);
		#1 check(o_separate_bcast, 2'b01);
		bus_ctrl_model_inst.send_words(3, 1'b0, 1'b1);
		bus_ctrl_model_inst.end_msg(1'b0);
		expect_msg(3, 1'b0, 1'b1);
		bus_ctrl_model_inst.send_words(3, 1'b1, 1'b1);
		bus_ctrl_model_inst.end_msg(1'b0);
		expect_msg(3, 1'b1, 1'b0);
		$display("broadcast test done");
		// Device keeps the hold option still against a host write while a terminal runs
		wr(rt_opt_pkg::ADDR_MASTER_SETUP, 16'h0001);
		wr(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0040);
		rdc(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0000);
		wr(rt_opt_pkg::ADDR_MASTER_SETUP, 16'h0000);
		wr(rt_opt_pkg::ADDR_T1_OPTIONS, 16'h0040);
		#1 check(o_temp_rx_enable, 2'b01);
		bus_ctrl_model_inst.send_words(32, 1'b0, 1'b0);
		check(got.size(), 0);
		bus_ctrl_model_inst.end_msg(1'b0);
		expect_msg(32, 1'b0, 1'b0);
		bus_ctrl_model_inst.send_words(2, 1'b0, 1'b0);
		bus_ctrl_model_inst.end_msg(1'b1);
		expect_msg(0, 1'b0, 1'b0);
		$display("hold buffer test done");
		// Mid-run reset must clear what the host set
		wr(rt_opt_pkg::ADDR_T2_OPTIONS, 16'h0300);
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		rdc(rt_opt_pkg::ADDR_T2_OPTIONS, 16'h0000);
		$display("mid-run reset test done");
		give_verdict();
	end
endmodule
`default_nettype wire
